// [core/sam_addr_mux.sv]
// SDRAM row/column address multiplexer with Wishbone configuration registers
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "sam_defs.svh"
////////////////////////////////////////////////////////////////////////////////
//Contract
// - Pick layout from bus, row, column fields
// - Pins 18 to 25 carry plain address
// - 16-bit bus: memory A0 on pin A1 (not built: a 16-bit area is flagged illegal and its pins pass through)
// - 32-bit bus: memory A0 on pin A2
// - Row code 00/01 is 11/12; col 00 is 8
// - 32/11/8: row shifts 8, banks 21,22
// - 32/12/8: row bits 8-21, banks 22,23
// - Column phase precharge line gets mode bit
// - Multiplexing only when area type is 100
module sam_addr_mux
   import sam_pkg::*;
#(
   parameter int AW = 26 // Address pin count
)
(
   input wire logic mclk_i,
   input wire logic nrst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Access request from the sequencer
   input wire sam_req_t req_i,
   // Address pins and status
   output sam_pins_t pins_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // Elaboration check: the mapping tables assume 26 pins
   if (AW != 26)
   begin : g_bad_aw
      $error("sam_addr_mux supports only AW = 26");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [31:0] area2_bus_ctrl_reg; // Area 2 type and bus size
   logic [31:0] area3_bus_ctrl_reg; // Area 3 type and bus size
   logic [31:0] sdram_ctrl_reg; // Row and column widths, area 2 low byte, area 3 byte 1
   logic wb_hit; // Cycle addressed to this slave
   logic [31:0] next_rdata; // Read data selected by address
   logic [31:0] wmask; // Byte-lane write mask

   assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // Ack one cycle after the strobe, dropped the next cycle
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= wb_hit;
   end

   // Register writes, byte lanes honoured; unmapped writes are dropped
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         area2_bus_ctrl_reg <= `SAM_AREA_RST;
         area3_bus_ctrl_reg <= `SAM_AREA_RST;
         sdram_ctrl_reg <= `SAM_SDCTRL_RST;
      end
      else if (wb_hit && wb_we_i)
      begin
         unique case (wb_adr_i)
            `SAM_OFS_AREA2:
               area2_bus_ctrl_reg <= (area2_bus_ctrl_reg & ~wmask) | (wb_dat_i & wmask);
            `SAM_OFS_AREA3:
               area3_bus_ctrl_reg <= (area3_bus_ctrl_reg & ~wmask) | (wb_dat_i & wmask);
            `SAM_OFS_SDCTRL:
               sdram_ctrl_reg <= (sdram_ctrl_reg & ~wmask) | (wb_dat_i & wmask);
            default:
            begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Field selection for the addressed area
   logic [7:0] area_ctrl; // Bus control byte of the selected area
   logic [7:0] sd_ctrl; // SDRAM width byte of the selected area
   logic [2:0] type_f; // Memory type field
   logic [1:0] bus_size_field; // Bus width code
   logic [1:0] row_width_field; // Row width code
   logic [1:0] col_width_field; // Column width code
   logic is_sdram; // Area holds SDRAM
   logic combo_ok; // Setting is a supported combination

   assign area_ctrl = req_i.area3 ? area3_bus_ctrl_reg[7:0] : area2_bus_ctrl_reg[7:0];
   assign sd_ctrl = req_i.area3 ? sdram_ctrl_reg[15:8] : sdram_ctrl_reg[7:0];
   assign type_f = area_ctrl[`SAM_TYPE_LSB +: 3];
   assign bus_size_field = area_ctrl[`SAM_BSZ_LSB +: 2];
   assign row_width_field = sd_ctrl[`SAM_ROW_LSB +: 2];
   assign col_width_field = sd_ctrl[`SAM_COL_LSB +: 2];
   assign is_sdram = (type_f == `SAM_TYPE_SDRAM);
   // Only the 32-bit, 8-column layouts with 11 or 12 row bits are built; anything else is flagged illegal
   assign combo_ok = (bus_size_field == `SAM_BSZ_32) && (col_width_field == `SAM_COL_8)
                     && (row_width_field == `SAM_ROW_11
                     || row_width_field == `SAM_ROW_12);

   // Read mux; unmapped addresses read zero
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      unique case (wb_adr_i)
         `SAM_OFS_AREA2: next_rdata = area2_bus_ctrl_reg;
         `SAM_OFS_AREA3: next_rdata = area3_bus_ctrl_reg;
         `SAM_OFS_SDCTRL: next_rdata = sdram_ctrl_reg;
         `SAM_OFS_STATUS: next_rdata = {28'h0000000, pins_o.legal, pins_o.sdram_sel,
                                        is_sdram, combo_ok};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Read data registered with the ack
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
         wb_dat_o <= 32'h0000_0000;
      else if (wb_hit)
         wb_dat_o <= next_rdata;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Address mapping
   logic [25:0] row_map; // Row-phase pin image
   logic [25:0] col_map; // Column-phase pin image
   logic [25:0] next_pins; // Pin image chosen by command

   // Build row and column images for the selected layout
   always_comb
   begin
      row_map = req_i.addr;
      col_map = req_i.addr;
      // Longword addressing: memory A0 sits on pin A2 in both images
      row_map[17:0] = req_i.addr[25:8];
      if (row_width_field == `SAM_ROW_12)
      begin
         // Banks on pins 14/15, pin 13 keeps its own bit in column phase
         col_map[15:14] = req_i.addr[23:22];
      end
      else
      begin
         // Banks on pins 13/14
         col_map[14:13] = req_i.addr[22:21];
      end
      col_map[12] = req_i.auto_pre;
      row_map[25:18] = req_i.addr[25:18];
      col_map[25:18] = req_i.addr[25:18];
   end

   // 16-bit bus would put memory A0 on pin A1; only built as a pass-through here
   // because no 16-bit layout is tabulated.
   always_comb
   begin
      next_pins = req_i.addr;
      if (is_sdram && combo_ok)
      begin
         unique case (req_i.cmd)
            SAM_CMD_ACTV: next_pins = row_map;
            SAM_CMD_RDWR: next_pins = col_map;
            SAM_CMD_NONE: next_pins = req_i.addr;
         endcase
      end
   end

   // Pins registered; they hold their value between requests
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
         pins_o <= '0;
      else if (req_i.valid)
      begin
         pins_o.pins <= next_pins;
         pins_o.sdram_sel <= is_sdram;
         pins_o.legal <= combo_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions
   a_plain_pins: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      $past(req_i.valid) |-> pins_o.pins[25:18] == $past(req_i.addr[25:18]))
      else $error("high address pins not plain");
   a_row_shift: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      $past(req_i.valid && is_sdram && combo_ok && req_i.cmd == SAM_CMD_ACTV)
      |-> pins_o.pins[17:0] == $past(req_i.addr[25:8]))
      else $error("row image wrong");
   a_precharge_bit: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      $past(req_i.valid && is_sdram && combo_ok && req_i.cmd == SAM_CMD_RDWR)
      |-> pins_o.pins[12] == $past(req_i.auto_pre))
      else $error("precharge line wrong");
   // Column image with 11 row bits: banks on 14/13, pins 11..0 keep their own bits
   a_bank_11: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      $past(req_i.valid && is_sdram && combo_ok && req_i.cmd == SAM_CMD_RDWR
      && row_width_field == `SAM_ROW_11)
      |-> (pins_o.pins[14:13] == $past(req_i.addr[22:21]))
      && (pins_o.pins[11:0] == $past(req_i.addr[11:0])))
      else $error("bank 11-row wrong");
   a_bank_12: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      $past(req_i.valid && is_sdram && combo_ok && req_i.cmd == SAM_CMD_RDWR
      && row_width_field == `SAM_ROW_12)
      |-> pins_o.pins[15:13] == {$past(req_i.addr[23:22]), $past(req_i.addr[13])})
      else $error("bank 12-row wrong");
   a_type_gate: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      $past(req_i.valid && !is_sdram) |-> pins_o.pins == $past(req_i.addr)
      && !pins_o.sdram_sel)
      else $error("non-SDRAM area multiplexed");
   a_combo_flag: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      $past(req_i.valid) |-> pins_o.legal == $past(bus_size_field == `SAM_BSZ_32
      && col_width_field == `SAM_COL_8 && row_width_field[1] == 1'b0))
      else $error("legal flag wrong");
   a_pins_hold: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      !req_i.valid ##1 nrst_i |-> $stable(pins_o.pins))
      else $error("pins moved without request");
endmodule

// [core/sam_defs.svh]
// Offsets, field positions, reset values and codes of the SDRAM address multiplexer
`ifndef SAM_DEFS_SVH
`define SAM_DEFS_SVH
`define SAM_OFS_AREA2 8'h00
`define SAM_OFS_AREA3 8'h04
`define SAM_OFS_SDCTRL 8'h08
`define SAM_OFS_STATUS 8'h0C
`define SAM_TYPE_LSB 0
`define SAM_BSZ_LSB 4
`define SAM_ROW_LSB 0
`define SAM_COL_LSB 2
`define SAM_AREA_RST 32'h0000_0000
`define SAM_SDCTRL_RST 32'h0000_0000
`define SAM_TYPE_SDRAM 3'h4
`define SAM_BSZ_16 2'h2
`define SAM_BSZ_32 2'h3
`define SAM_ROW_11 2'h0
`define SAM_ROW_12 2'h1
`define SAM_COL_8 2'h0
`define SAM_PLAIN_LSB 18
`endif

// [core/sam_pkg.sv]
// Types shared by the SDRAM address multiplexer
package sam_pkg;
   // Command presented with the address
   typedef enum logic [1:0] {SAM_CMD_NONE, SAM_CMD_ACTV, SAM_CMD_RDWR} sam_cmd_t;
   // Access request from the command sequencer
   typedef struct packed
   {
      logic valid;
      logic area3;
      sam_cmd_t cmd;
      logic auto_pre;
      logic [25:0] addr;
   } sam_req_t;
   // Pin group driven towards the memory
   typedef struct packed
   {
      logic sdram_sel;
      logic legal;
      logic [25:0] pins;
   } sam_pins_t;
endpackage

// [verif/sam_addr_mux_tb.sv]
// Self-checking bench for the SDRAM address multiplexer
`timescale 1ns/1ps
`include "sam_defs.svh"
module sam_addr_mux_tb
   import sam_pkg::*;
;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'hF;
   logic [31:0] wdat = 32'h0;
   logic [31:0] dat;
   logic [31:0] rdat;
   logic ack;
   sam_req_t req = '0;
   sam_pins_t pins;
   sam_cmd_t mcmd = SAM_CMD_NONE; // Command lines as the memory sees them
   logic [13:0] mrow;
   logic map;
   logic [25:0] a;
   int err_count = 0;
   int compares = 0;
   always #2 clk = ~clk;
   sam_addr_mux DUT (.mclk_i(clk), .nrst_i(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat),
      .wb_ack_o(ack), .req_i(req), .pins_o(pins));
   sam_sdram_model u_mem (.mclk_i(clk), .cmd_i(mcmd), .pins_i(pins), .row_o(mrow), .ap_o(map));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Classic cycle: hold everything until ack is sampled, then release
   task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d,
      input logic [3:0] s);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= d;
      sel <= s;
      do @(posedge clk); while (ack !== 1'b1);
      rdat = dat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
      wb(1'b0, ad, 32'h0, 4'hF);
      chk("register", rdat, exp);
   endtask
   // One request, then the memory model sees the pins while they stand
   task automatic rq(input logic a3, input sam_cmd_t c, input logic ap, input logic [25:0] e,
      input logic [1:0] st);
      @(posedge clk);
      req <= {1'b1, a3, c, ap, a};
      @(posedge clk);
      req.valid <= 1'b0;
      mcmd <= c;
      repeat (2) @(posedge clk);
      mcmd <= SAM_CMD_NONE;
      chk("pins", {6'h0, pins.pins}, {6'h0, e});
      chk("flags", {30'h0, pins.sdram_sel, pins.legal}, {30'h0, st});
   endtask
   // Expected pins, worked out from the pin tables
   function automatic logic [25:0] ex(input logic ok, input sam_cmd_t c, input logic r12,
      input logic ap);
      logic [25:0] p;
      p = a;
      if (ok && c == SAM_CMD_ACTV)
         p[17:0] = a[25:8];
      if (ok && c == SAM_CMD_RDWR)
      begin
         p[12] = ap;
         if (r12)
            p[15:14] = a[23:22];
         else
            p[14:13] = a[22:21];
      end
      return p;
   endfunction
   task automatic final_report;
      if (err_count == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      rd(`SAM_OFS_AREA2, 32'h0);
      wb(1'b1, 8'h10, 32'hFFFF_FFFF, 4'hF);
      rd(8'h10, 32'h0);
      wb(1'b1, `SAM_OFS_AREA2, 32'h0000_0034, 4'hF);
      wb(1'b1, `SAM_OFS_AREA3, 32'h0000_0034, 4'hF);
      wb(1'b1, `SAM_OFS_SDCTRL, 32'h0000_0001, 4'hF);
      rd(`SAM_OFS_SDCTRL, 32'h0000_0001);
      // Area 2 has 12 row bits, area 3 has 11; the two addresses are complements
      for (int i = 0; i < 8; i++)
      begin
         a = i[2] ? 26'h2AB_CDEF : 26'h154_3210;
         rq(i[0], SAM_CMD_ACTV, i[1], ex(1'b1, SAM_CMD_ACTV, !i[0], i[1]), 2'b11);
         @(posedge clk);
         chk("row", {18'h0, mrow}, {18'h0, a[23:10]});
         rq(i[0], SAM_CMD_RDWR, i[1], ex(1'b1, SAM_CMD_RDWR, !i[0], i[1]), 2'b11);
         @(posedge clk);
         chk("precharge", {31'h0, map}, {31'h0, i[1]});
         rq(i[0], SAM_CMD_NONE, i[1], a, 2'b11);
      end
      // Status: pins legal, pins SDRAM, area 3 is SDRAM, area 3 setting supported
      rd(`SAM_OFS_STATUS, 32'h0000_000F);
      wb(1'b1, `SAM_OFS_AREA2, 32'h0000_0024, 4'hF);
      rq(1'b0, SAM_CMD_ACTV, 1'b0, a, 2'b10);
      // A 16-bit area is SDRAM but unsupported: legal and combination bits low
      rd(`SAM_OFS_STATUS, 32'h0000_0006);
      wb(1'b1, `SAM_OFS_SDCTRL, 32'h0000_0401, 4'hF);
      rq(1'b1, SAM_CMD_RDWR, 1'b1, a, 2'b10);
      wb(1'b1, `SAM_OFS_AREA3, 32'h0000_0030, 4'hF);
      rq(1'b1, SAM_CMD_ACTV, 1'b0, a, 2'b00);
      wb(1'b1, `SAM_OFS_AREA3, 32'hFF00_0034, 4'h1);
      rd(`SAM_OFS_AREA3, 32'h0000_0034);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      chk("pins", {4'h0, pins}, 32'h0);
      rd(`SAM_OFS_AREA3, 32'h0);
      final_report;
   end
   // Watchdog
   initial
   begin
      repeat (20000) @(posedge clk);
      err_count++;
      final_report;
   end
endmodule

// [verif/sam_sdram_model.sv]
// Behavioural SDRAM seen from the address pins of a 32-bit bus
`timescale 1ns/1ps
module sam_sdram_model
   import sam_pkg::*;
(
   input wire logic mclk_i,
   input wire sam_cmd_t cmd_i,
   input wire sam_pins_t pins_i,
   output logic [13:0] row_o,
   output logic ap_o
);
   // Memory line 0 hangs on pin 2, so pins 15..2 feed lines 13..0
   always_ff @(posedge mclk_i)
   begin
      if (cmd_i == SAM_CMD_ACTV)
         row_o <= pins_i.pins[15:2]; // Row latched with activate
      else if (cmd_i == SAM_CMD_RDWR)
         ap_o <= pins_i.pins[12]; // Precharge select line
   end
endmodule
